// [shared/aeb_pkg.sv]
// constants shared by the alarm event buffer design
package aeb_pkg;
    // clock and runtime timing
    localparam int unsigned CLK_PERIOD_NS = 100;          // clk_sys period in ns
    localparam int unsigned MS_PERIOD_NS  = 1000000;      // one millisecond in ns
    localparam int unsigned CYC_PER_MS    = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [31:0] MS_PER_DAY    = 32'h0526_5C00; // 86,400,000 ms
    // field widths of one record
    localparam int CODE_W  = 16;
    localparam int VAL_W   = 32;
    localparam int DAYS_W  = 16;
    localparam int MS_W    = 32;
    // arrival part: code, fixed value, float value, arrival days, arrival ms
    localparam int LO_CODE  = 0;
    localparam int LO_FIXED = 16;
    localparam int LO_FLOAT = 48;
    localparam int LO_ADAYS = 80;
    localparam int LO_AMS   = 96;
    localparam int LO_W     = 128;
    // removal part: removal days, removal ms
    localparam int HI_RDAYS = 0;
    localparam int HI_RMS   = 16;
    localparam int HI_W     = 48;
    // buffer and history geometry
    localparam int BUF_DEPTH  = 8;
    localparam int HIST_BASE  = 8;
    localparam int HIST_DEPTH = 56;
    localparam int MEM_DEPTH  = 64;
    localparam logic [3:0] OVERWRITE_IDX = 4'h6;           // next-to-last entry
    // status word bit carrying the alarm summary
    localparam int STAT_ALARM_BIT = 7;
    // register byte offsets
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_COUNT  = 8'h04;
    localparam logic [7:0] ADR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADR_IRQ_MK = 8'h0C;
    localparam logic [7:0] ADR_SEL    = 8'h10;
    localparam logic [7:0] ADR_CODE   = 8'h14;
    localparam logic [7:0] ADR_FIXED  = 8'h18;
    localparam logic [7:0] ADR_FLOAT  = 8'h1C;
    localparam logic [7:0] ADR_ADAYS  = 8'h20;
    localparam logic [7:0] ADR_AMS    = 8'h24;
    localparam logic [7:0] ADR_RDAYS  = 8'h28;
    localparam logic [7:0] ADR_RMS    = 8'h2C;
    localparam logic [7:0] ADR_FILL   = 8'h30;
    // reset values
    localparam logic [31:0] RST_COUNT = 32'h0000_0000;
    localparam logic [2:0]  RST_MASK  = 3'h0;
    // interrupt bit positions
    localparam int IRQ_RAISE = 0;
    localparam int IRQ_CLEAR = 1;
    localparam int IRQ_MOVE  = 2;
endpackage

// [core/aeb_mem.sv]
// record memory for buffer entries and history, registered read
`timescale 1ns/1ps
module aeb_mem #(
    parameter int LO_W  = 128,
    parameter int HI_W  = 48,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    input  wire logic                 we_lo,
    input  wire logic                 we_hi,
    input  wire logic [AW-1:0]        waddr,
    input  wire logic [HI_W+LO_W-1:0] wdata,
    input  wire logic [AW-1:0]        raddr,
    output logic      [HI_W+LO_W-1:0] rdata_q
);
    // arrival and removal halves are written separately
    logic [LO_W-1:0] lo_mem [DEPTH];
    logic [HI_W-1:0] hi_mem [DEPTH];

    // write ports, no reset on the array
    always_ff @(posedge clk_sys) begin
        if (ce && we_lo) begin
            lo_mem[waddr] <= wdata[LO_W-1:0];
        end
        if (ce && we_hi) begin
            hi_mem[waddr] <= wdata[HI_W+LO_W-1:LO_W];
        end
    end

    // read data comes out of a register one cycle after the address
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= {hi_mem[raddr], lo_mem[raddr]};
        end
    end
endmodule

// [core/aeb_runtime.sv]
// free-running runtime counter: days and milliseconds of the day
`timescale 1ns/1ps
module aeb_runtime #(
    parameter int unsigned CYC_PER_MS = 10000
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        ce,
    output logic [31:0]      ms_q,
    output logic [15:0]      days_q
);
    logic [31:0] pre_q;                                  // cycle prescaler
    wire         tick    = (pre_q == 32'(CYC_PER_MS - 1));
    wire         day_end = (ms_q == aeb_pkg::MS_PER_DAY - 32'h1);

    // prescaler gives one tick per millisecond
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_q <= 32'h0;
        end else if (ce) begin
            pre_q <= tick ? 32'h0 : pre_q + 32'h1;
        end
    end

    // millisecond of day wraps into the day count
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ms_q   <= 32'h0;
            days_q <= 16'h0;
        end else if (ce && tick) begin
            ms_q <= day_end ? 32'h0 : ms_q + 32'h1;
            if (day_end) begin
                days_q <= days_q + 16'h1;
            end
        end
    end
endmodule

// [core/aeb_top.sv]
// alarm event buffer with history store and wishbone register slave
`timescale 1ns/1ps
module aeb_top #(
    parameter int unsigned CYC_PER_MS = aeb_pkg::CYC_PER_MS
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        alm_valid,
    input  wire logic        alm_clear,
    input  wire logic [15:0] alm_code,
    input  wire logic [31:0] alm_fixed,
    input  wire logic [31:0] alm_float,
    output logic             alm_ready,
    output logic             alarm_active,
    output logic             irq
);
    localparam int LW = aeb_pkg::LO_W;
    localparam int HW = aeb_pkg::HI_W;

    typedef enum logic [2:0] {ST_IDLE, ST_BUSRD, ST_MRD, ST_MWR, ST_FIN} aeb_state_t;

    // controller state
    aeb_state_t  state_q, state_d;
    logic [3:0]  cnt_q;                    // entries in use in the buffer
    logic [7:0]  act_q;                    // entry holds a still active alarm
    logic [15:0] code_q [8];               // codes kept for clear lookup
    logic [5:0]  hwp_q;                    // history ring write slot
    logic [5:0]  hcnt_q;                   // entries held in history
    logic [3:0]  src_q, dst_q;             // compaction read and write index
    logic        hold_q;                   // new alarm waits for compaction
    logic [LW-1:0] hold_rec_q;             // record of the waiting alarm
    logic        flush_q;                  // software asked for a move
    logic [31:0] occ_q;                    // alarm occurrence counter
    logic [2:0]  ist_q, imask_q;           // interrupt status and mask
    logic [5:0]  sel_q;                    // entry selected for reading
    // runtime and memory
    logic [31:0] ms_now;
    logic [15:0] days_now;
    logic [LW+HW-1:0] rdata;
    logic        we_lo, we_hi;
    logic [5:0]  waddr, raddr;
    logic [LW+HW-1:0] wdata;

    // lowest active entry whose code matches
    function automatic logic [3:0] find_code(input logic [15:0] c, input logic [7:0] act,
                                             input logic [127:0] codes);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (act[i] && codes[i*16 +: 16] == c) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // byte-lane merge of a register write
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nv,
                                               input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (nv & m);
    endfunction

    // physical slot of history entry h, youngest is h = 0
    function automatic logic [5:0] hist_slot(input logic [5:0] wp, input logic [5:0] h);
        logic [6:0] t;
        t = 7'(wp) + 7'(aeb_pkg::HIST_DEPTH - 1) - 7'(h);
        if (t >= 7'(aeb_pkg::HIST_DEPTH)) begin
            t = t - 7'(aeb_pkg::HIST_DEPTH);
        end
        return 6'(aeb_pkg::HIST_BASE) + t[5:0];
    endfunction

    // flatten codes for the lookup function
    logic [127:0] codes_flat;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_codes
            assign codes_flat[gi*16 +: 16] = code_q[gi];
        end
    endgenerate

    aeb_runtime #(.CYC_PER_MS(CYC_PER_MS)) u_rt (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .ms_q    (ms_now),
        .days_q  (days_now)
    );

    aeb_mem #(.LO_W(LW), .HI_W(HW), .DEPTH(aeb_pkg::MEM_DEPTH), .AW(6)) u_mem (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .we_lo   (we_lo),
        .we_hi   (we_hi),
        .waddr   (waddr),
        .wdata   (wdata),
        .raddr   (raddr),
        .rdata_q (rdata)
    );

    // bus decode
    wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire is_field  = (wb_adr_i >= aeb_pkg::ADR_CODE) && (wb_adr_i <= aeb_pkg::ADR_RMS);
    wire field_rd  = wb_req & ~wb_we_i & is_field;
    wire simple    = wb_req & ~field_rd;
    wire wr_acc    = simple & wb_we_i;
    wire wr_count  = wr_acc & (wb_adr_i == aeb_pkg::ADR_COUNT);
    wire rd_ist    = simple & ~wb_we_i & (wb_adr_i == aeb_pkg::ADR_IRQ_ST);
    wire [31:0] count_new = lane_merge(occ_q, wb_dat_i, wb_sel_i);

    // alarm request decode
    wire       idle      = (state_q == ST_IDLE);
    wire       take_alm  = idle & alm_ready & alm_valid;
    wire       take_rise = take_alm & ~alm_clear;
    wire [3:0] clr_idx   = find_code(alm_code, act_q, codes_flat);
    // clear needs no acknowledge, only the cause going away
    wire       take_clr  = take_alm & alm_clear & ~clr_idx[3];
    wire       buf_full  = (cnt_q == 4'(aeb_pkg::BUF_DEPTH));
    wire       all_act   = (act_q == 8'hFF);
    wire       rise_free = take_rise & ~buf_full;
    wire       rise_ovw  = take_rise & buf_full & all_act;
    wire       rise_cmp  = take_rise & buf_full & ~all_act;
    wire       take_bus  = idle & ~take_alm & field_rd;
    wire       take_fl   = idle & ~take_alm & ~field_rd & flush_q;
    // new record: code, fixed, float, arrival days and ms
    wire [LW-1:0] new_rec = {ms_now, days_now, alm_float, alm_fixed, alm_code};
    wire [HW-1:0] rem_now = {ms_now, days_now};
    wire          last_src = (src_q == cnt_q - 4'h1);
    wire          src_act  = act_q[src_q[2:0]];

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (rise_cmp || take_fl) begin
                    state_d = (cnt_q == 4'h0) ? ST_FIN : ST_MRD;
                end else if (take_bus) begin
                    state_d = ST_BUSRD;
                end
            end
            ST_BUSRD: state_d = ST_IDLE;
            ST_MRD:   state_d = ST_MWR;
            ST_MWR:   state_d = last_src ? ST_FIN : ST_MRD;
            ST_FIN:   state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    // selected entry: buffer slot or history slot, and whether it holds data
    wire [5:0] sel_hist  = sel_q - 6'(aeb_pkg::HIST_BASE);
    wire       sel_inbuf = (sel_q < 6'(aeb_pkg::HIST_BASE));
    wire       sel_ok    = sel_inbuf ? (4'(sel_q) < cnt_q) : (sel_hist < hcnt_q);
    wire [5:0] sel_phys  = sel_inbuf ? sel_q : hist_slot(hwp_q, sel_hist);
    // compaction reads source, otherwise the selected entry is fetched
    assign raddr = (state_q == ST_MRD) ? {2'b00, src_q} : sel_phys;

    // memory write selection
    wire mv_hist = (state_q == ST_MWR) & ~src_act;
    wire mv_down = (state_q == ST_MWR) & src_act & (dst_q != src_q);
    wire fin_wr  = (state_q == ST_FIN) & hold_q;
    assign we_lo = rise_free | rise_ovw | mv_hist | mv_down | fin_wr;
    assign we_hi = we_lo | take_clr;
    // write slot chosen by event kind
    assign waddr = rise_free ? {2'b00, cnt_q} :
                   rise_ovw  ? {2'b00, aeb_pkg::OVERWRITE_IDX} :
                   take_clr  ? {2'b00, clr_idx} :
                   mv_hist   ? 6'(aeb_pkg::HIST_BASE) + hwp_q :
                   {2'b00, dst_q};
    // removal time on clear, zeros on a fresh entry
    assign wdata = take_clr ? {rem_now, {LW{1'b0}}} :
                   (mv_hist | mv_down) ? rdata :
                   fin_wr ? {{HW{1'b0}}, hold_rec_q} :
                   {{HW{1'b0}}, new_rec};

    // active-entry mask of the entries below n
    wire [7:0] keep_mask = 8'((9'h1 << dst_q) - 9'h1);
    wire [7:0] dst_bit   = 8'(9'h1 << dst_q);

    // state, compaction indices and waiting alarm
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q    <= ST_IDLE;
            src_q      <= 4'h0;
            dst_q      <= 4'h0;
            hold_q     <= 1'b0;
            hold_rec_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            if (rise_cmp || take_fl) begin
                src_q      <= 4'h0;
                dst_q      <= 4'h0;
                hold_q     <= rise_cmp;
                hold_rec_q <= new_rec;
            end else if (state_q == ST_MWR) begin
                src_q <= src_q + 4'h1;
                dst_q <= src_act ? dst_q + 4'h1 : dst_q;
            end else if (state_q == ST_FIN) begin
                hold_q <= 1'b0;
            end
        end
    end

    // buffer occupancy and active flags
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 4'h0;
            act_q <= 8'h00;
        end else if (ce) begin
            if (rise_free) begin
                cnt_q               <= cnt_q + 4'h1;
                act_q[cnt_q[2:0]]   <= 1'b1;
            end else if (take_clr) begin
                act_q[clr_idx[2:0]] <= 1'b0;
            end else if (mv_down) begin
                act_q[dst_q[2:0]]   <= 1'b1;
            end else if (state_q == ST_FIN) begin
                cnt_q <= hold_q ? dst_q + 4'h1 : dst_q;
                act_q <= (act_q & keep_mask) | (hold_q ? dst_bit : 8'h00);
            end
        end
    end

    // codes follow their entries
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            code_q <= '{default: 16'h0};
        end else if (ce) begin
            if (rise_free) begin
                code_q[cnt_q[2:0]] <= alm_code;
            end else if (rise_ovw) begin
                code_q[aeb_pkg::OVERWRITE_IDX[2:0]] <= alm_code;
            end else if (mv_down) begin
                code_q[dst_q[2:0]] <= code_q[src_q[2:0]];
            end else if (fin_wr) begin
                code_q[dst_q[2:0]] <= hold_rec_q[15:0];
            end
        end
    end

    // history ring: oldest entry lost once all slots are used
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hwp_q  <= 6'h0;
            hcnt_q <= 6'h0;
        end else if (ce && mv_hist) begin
            // newest move becomes history index 8
            hwp_q  <= (hwp_q == 6'(aeb_pkg::HIST_DEPTH - 1)) ? 6'h0 : hwp_q + 6'h1;
            if (hcnt_q != 6'(aeb_pkg::HIST_DEPTH)) begin
                hcnt_q <= hcnt_q + 6'h1;
            end
        end
    end

    // occurrence counter, flush request, select, mask
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            occ_q   <= aeb_pkg::RST_COUNT;
            flush_q <= 1'b0;
            sel_q   <= 6'h0;
            imask_q <= aeb_pkg::RST_MASK;
        end else if (ce) begin
            occ_q <= (wr_count ? count_new : occ_q) + {31'h0, take_rise};
            // writing zero moves cleared entries out; request wins over start
            flush_q <= (wr_count && count_new == 32'h0) | (flush_q & ~take_fl);
            if (wr_acc && wb_adr_i == aeb_pkg::ADR_SEL && wb_sel_i[0]) begin
                sel_q <= wb_dat_i[5:0];
            end
            if (wr_acc && wb_adr_i == aeb_pkg::ADR_IRQ_MK && wb_sel_i[0]) begin
                imask_q <= wb_dat_i[2:0];
            end
        end
    end

    // sticky interrupt status, read clears, a new event wins
    wire [2:0] ev = {state_q == ST_FIN, take_clr, take_rise};
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ist_q <= 3'h0;
        end else if (ce) begin
            ist_q <= ev | (ist_q & ~{3{rd_ist}});
        end
    end

    // field of the fetched record, zero for an empty index
    logic [31:0] field_val;
    always_comb begin
        case (wb_adr_i)
            aeb_pkg::ADR_CODE:  field_val = {16'h0, rdata[aeb_pkg::LO_CODE +: 16]};
            aeb_pkg::ADR_FIXED: field_val = rdata[aeb_pkg::LO_FIXED +: 32];
            aeb_pkg::ADR_FLOAT: field_val = rdata[aeb_pkg::LO_FLOAT +: 32];
            aeb_pkg::ADR_ADAYS: field_val = {16'h0, rdata[aeb_pkg::LO_ADAYS +: 16]};
            aeb_pkg::ADR_AMS:   field_val = rdata[aeb_pkg::LO_AMS +: 32];
            aeb_pkg::ADR_RDAYS: field_val = {16'h0, rdata[LW + aeb_pkg::HI_RDAYS +: 16]};
            aeb_pkg::ADR_RMS:   field_val = rdata[LW + aeb_pkg::HI_RMS +: 32];
            default:            field_val = 32'h0;
        endcase
    end

    // summary flag in the first status word
    wire [31:0] status_word = 32'(act_q != 8'h00) << aeb_pkg::STAT_ALARM_BIT;
    logic [31:0] simple_val;
    always_comb begin
        case (wb_adr_i)
            aeb_pkg::ADR_STATUS: simple_val = status_word;
            aeb_pkg::ADR_COUNT:  simple_val = occ_q;
            aeb_pkg::ADR_IRQ_ST: simple_val = {29'h0, ist_q};
            aeb_pkg::ADR_IRQ_MK: simple_val = {29'h0, imask_q};
            aeb_pkg::ADR_SEL:    simple_val = {26'h0, sel_q};
            aeb_pkg::ADR_FILL:   simple_val = {10'h0, hcnt_q, 4'h0, cnt_q, act_q};
            default:             simple_val = 32'h0;
        endcase
    end

    // bus answer: one cycle for plain registers and all writes, two or more for record field reads (two when idle)
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce) begin
            wb_ack_o <= simple | (state_q == ST_BUSRD);
            if (state_q == ST_BUSRD) begin
                wb_dat_o <= sel_ok ? field_val : 32'h0;
            end else if (simple) begin
                wb_dat_o <= wb_we_i ? 32'h0 : simple_val;
            end
        end
    end

    // registered outputs toward sources and the system
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            alm_ready    <= 1'b0;
            alarm_active <= 1'b0;
            irq          <= 1'b0;
        end else if (ce) begin
            alm_ready    <= (state_d == ST_IDLE);
            alarm_active <= (act_q != 8'h00);
            irq          <= |(ist_q & imask_q);
        end
    end
endmodule

// [verification/aeb_top_props.sv]
// port-level assertion checker for the alarm event buffer
`timescale 1ns/1ps
module aeb_top_props #(
    parameter int unsigned CYC_PER_MS = 4
) (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        ce,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        alm_valid,
    input wire logic        alm_clear,
    input wire logic        alm_ready,
    input wire logic        alarm_active,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // read answers on the bus, by offset
    wire logic rd_ack = wb_ack_o & ~wb_we_i;
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over one cycle");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i & wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
    property p_ack_bound; wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:60] wb_ack_o; endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("request never answered");
    property p_unmapped; rd_ack && wb_adr_i == 8'h40 |-> wb_dat_o == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_stat_bits; rd_ack && wb_adr_i == aeb_pkg::ADR_STATUS |-> (wb_dat_o & ~32'h80) == 0;
    endproperty
    a_stat_bits: assert property (p_stat_bits)
        else $error("status word has bits other than the alarm flag");
    property p_raise_act; alm_valid && alm_ready && !alm_clear |=> ##1 alarm_active; endproperty
    a_raise_act: assert property (p_raise_act)
        else $error("alarm flag missing after raise");
    property p_fall_cause; $fell(alarm_active) |-> $past(alm_valid & alm_ready & alm_clear, 2);
    endproperty
    a_fall_cause: assert property (p_fall_cause)
        else $error("alarm flag dropped without a clear");
    property p_rst_idle; $rose(nrst) |-> !alarm_active && !wb_ack_o; endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("outputs busy just after reset");
    c_raise: cover property (alm_valid && alm_ready && !alm_clear);
    c_clear: cover property (alm_valid && alm_ready && alm_clear);
    c_irq: cover property (irq);
endmodule

// [verification/aeb_alarm_src.sv]
// behavioural source of alarm raise and clear requests
`timescale 1ns/1ps
module aeb_alarm_src (
    input  wire logic        clk_sys,
    input  wire logic        alm_ready,
    output logic             alm_valid = 1'b0,
    output logic             alm_clear = 1'b0,
    output logic [15:0]      alm_code  = 16'hFFFF,
    output logic [31:0]      alm_fixed = 32'hFFFF_FFFF,
    output logic [31:0]      alm_float = 32'hFFFF_FFFF
);
    // hold one request until the edge that takes it, then show inverted data
    task automatic send(input logic clr, input logic [15:0] c);
        @(posedge clk_sys);
        alm_valid <= 1'b1;
        alm_clear <= clr;
        alm_code  <= c;
        alm_fixed <= {16'h0F00, c};
        alm_float <= {c, 16'h3F80};
        do @(posedge clk_sys); while (alm_ready !== 1'b1);
        alm_valid <= 1'b0;
        alm_code  <= ~c;
        alm_fixed <= ~{16'h0F00, c};
        alm_float <= ~{c, 16'h3F80};
    endtask
endmodule

// [verification/aeb_top_tb.sv]
// self-checking bench for the alarm event buffer
`timescale 1ns/1ps
module aeb_top_tb;
    logic        clk_sys = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, d, a;
    logic        wb_ack_o, alm_valid, alm_clear, alm_ready, alarm_active, irq;
    logic [15:0] alm_code;
    logic [31:0] alm_fixed, alm_float;
    int          n_fail = 0, tests_run = 0;
    always #50 clk_sys = ~clk_sys;
    aeb_top #(.CYC_PER_MS(4)) dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .alm_valid(alm_valid), .alm_clear(alm_clear), .alm_code(alm_code),
        .alm_fixed(alm_fixed), .alm_float(alm_float), .alm_ready(alm_ready),
        .alarm_active(alarm_active), .irq(irq));
    aeb_alarm_src src (.clk_sys(clk_sys), .alm_ready(alm_ready), .alm_valid(alm_valid),
        .alm_clear(alm_clear), .alm_code(alm_code), .alm_fixed(alm_fixed),
        .alm_float(alm_float));
    // verdict and end of run
    task automatic stop_test();
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic cycle, held until ack
    task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= ad;
        wb_dat_i <= wd;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic fld(input logic [5:0] ix, input logic [7:0] ad, output logic [31:0] rd);
        wb(1'b1, aeb_pkg::ADR_SEL, {26'h0, ix}, rd);
        wb(1'b0, ad, 32'h0, rd);
    endtask
    // code, both value forms and arrival day of one entry
    task automatic entry(input logic [5:0] ix, input logic [15:0] c);
        logic [31:0] r;
        fld(ix, aeb_pkg::ADR_CODE, r);
        chk("code", {16'h0, c}, r);
        fld(ix, aeb_pkg::ADR_FIXED, r);
        chk("fixed", {16'h0F00, c}, r);
        fld(ix, aeb_pkg::ADR_FLOAT, r);
        chk("float", {c, 16'h3F80}, r);
        fld(ix, aeb_pkg::ADR_ADAYS, r);
        chk("arrival days", 32'h0, r);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        wb(1'b0, aeb_pkg::ADR_COUNT, 32'h0, d);
        chk("count", aeb_pkg::RST_COUNT, d);
        wb(1'b0, aeb_pkg::ADR_STATUS, 32'h0, d);
        chk("status", 32'h0, d);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF, d);
        wb(1'b0, 8'h40, 32'h0, d);
        chk("unmapped", 32'h0, d);
        $display("test reset done");
        for (int i = 0; i < 3; i++) src.send(1'b0, 16'h0100 + i[15:0]);
        src.send(1'b1, 16'h0101);
        repeat (3) @(posedge clk_sys);
        wb(1'b0, aeb_pkg::ADR_COUNT, 32'h0, d);
        chk("count", 32'h3, d);
        wb(1'b0, aeb_pkg::ADR_STATUS, 32'h0, d);
        chk("status", 32'h80, d);
        for (int i = 0; i < 3; i++) entry(i[5:0], 16'h0100 + i[15:0]);
        fld(6'h01, aeb_pkg::ADR_AMS, a);
        fld(6'h01, aeb_pkg::ADR_RMS, d);
        chk("removal order", 32'h1, {31'h0, d >= a});
        fld(6'h01, aeb_pkg::ADR_RDAYS, d);
        chk("removal days", 32'h0, d);
        fld(6'h00, aeb_pkg::ADR_RMS, d);
        chk("removal unset", 32'h0, d);
        $display("test raise and clear done");
        wb(1'b1, aeb_pkg::ADR_IRQ_MK, 32'h1, d);
        repeat (3) @(posedge clk_sys);
        chk("irq", 32'h1, {31'h0, irq});
        wb(1'b0, aeb_pkg::ADR_IRQ_ST, 32'h0, d);
        chk("irq status", 32'h3, d);
        wb(1'b0, aeb_pkg::ADR_IRQ_ST, 32'h0, d);
        chk("irq status", 32'h0, d);
        repeat (3) @(posedge clk_sys);
        chk("irq", 32'h0, {31'h0, irq});
        wb(1'b1, aeb_pkg::ADR_IRQ_MK, 32'h0, d);
        $display("test interrupt done");
        for (int i = 3; i < 9; i++) src.send(1'b0, 16'h0100 + i[15:0]);
        repeat (40) @(posedge clk_sys);
        entry(6'h07, 16'h0108);
        entry(6'h01, 16'h0102);
        entry(6'h08, 16'h0101);
        src.send(1'b0, 16'h0109);
        repeat (3) @(posedge clk_sys);
        entry(6'h06, 16'h0109);
        entry(6'h07, 16'h0108);
        wb(1'b0, aeb_pkg::ADR_COUNT, 32'h0, d);
        chk("count", 32'hA, d);
        $display("test full buffer done");
        for (int i = 0; i < 10; i++) src.send(1'b1, 16'h0100 + i[15:0]);
        repeat (4) @(posedge clk_sys);
        wb(1'b0, aeb_pkg::ADR_STATUS, 32'h0, d);
        chk("status", 32'h0, d);
        entry(6'h00, 16'h0100);
        wb(1'b1, aeb_pkg::ADR_COUNT, 32'h0, d);
        entry(6'h08, 16'h0108);
        wb(1'b0, aeb_pkg::ADR_FILL, 32'h0, d);
        chk("fill", 32'h0009_0000, d);
        wb(1'b0, aeb_pkg::ADR_COUNT, 32'h0, d);
        chk("count", 32'h0, d);
        $display("test clear all done");
        stop_test();
    end
    // cut a hang short
    initial begin
        #(100 * 20000);
        n_fail++;
        stop_test();
    end
endmodule
bind aeb_top aeb_top_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (.clk_sys(clk_sys), .nrst(nrst),
    .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alm_valid(alm_valid), .alm_clear(alm_clear),
    .alm_ready(alm_ready), .alarm_active(alarm_active), .irq(irq));
